/* rtl/sfl_fastlock_config_regs.sv */
// Fastlock condition word and fraction extension word of a dual synthesizer.
// Assumes lock and divider inputs come from logic on i_mclk; serial, enable
// and reference pins are asynchronous and are synchronised here.
//
// What this block does
// - Select 0 floats the test/lock pin; 1 drives high, 2 drives low.
// - Selects 3, 4, 5 give combined, main, auxiliary digital lock, push-pull.
// - Selects 6-8 give analog lock open-drain; 9-11 the same push-pull.
// - Selects 12-15 give aux R, aux N, main R, main N divided by two.
// - Auxiliary prescaler bit: 0 picks 8/9, 1 picks 16/17.
// - Main pump polarity bit: 0 negative, 1 positive, positive at reset.
// - Auxiliary pump polarity bit: 1 positive, 0 negative.
// - Reference output enable: 0 floats pin, 1 buffers reference input.
// - Doubler bit 1 feeds twice reference to main R counter only.
// - Modulator order code 0 fourth, 2 second, 3 third order.
// - Modulator order code 1 turns the modulator off, test use only.
// - Dither code 0 off, 1 weak, 2 strong, 3 reserved.
// - With auto power-up set, frequency word writes clear both power-downs.
// - Chip enable low suppresses the auto power-up action.
// - Access bit 0 gives a 12-bit numerator, extension bits ignored.
// - Access bit 1 joins ten extension bits above twelve base bits.
// - Extension word in default mode is forced to its defaults.
// - Chip enable low keeps the auxiliary loop powered down.
`timescale 1ns/1ps
module sfl_fastlock_config_regs
  import sfl_pkg::*;
#(
  parameter int unsigned WORD_BITS = SFL_WORD_BITS
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  input wire logic i_serial_latch,
  input wire logic i_chip_enable,
  input wire logic i_ref_input_pin,
  input wire logic i_ext_access,
  input wire logic [11:0] i_frac_num_base,
  input wire logic [11:0] i_frac_den_base,
  input wire logic i_pd_load,
  input wire logic i_main_pd_value,
  input wire logic i_aux_pd_value,
  input wire logic i_main_dld,
  input wire logic i_aux_dld,
  input wire logic i_main_ald,
  input wire logic i_aux_ald,
  input wire logic i_aux_r_div,
  input wire logic i_aux_n_div,
  input wire logic i_main_r_div,
  input wire logic i_main_n_div,
  output logic o_test_lock_pin_out,
  output logic o_test_lock_pin_oe,
  output logic o_ref_output_pin_out,
  output logic o_ref_output_pin_oe,
  output logic o_aux_prescaler_16,
  output logic o_main_pump_polarity,
  output logic o_aux_pump_polarity,
  output logic o_ref_doubler_enable,
  output logic o_modulator_enable,
  output logic [2:0] o_modulator_order,
  output logic [1:0] o_dither_level,
  output logic o_main_loop_powerdown,
  output logic o_aux_loop_powerdown,
  output logic [21:0] o_frac_numerator,
  output logic [21:0] o_frac_denominator,
  output logic o_word_loaded
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (WORD_BITS != SFL_WORD_BITS) begin : g_bad_width
    $error("sfl_fastlock_config_regs serves 24-bit words only");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sclk_s;
  logic sdata_s;
  logic slatch_s;
  logic ce_s;
  logic ref_s;

  sfl_pin_sync #(.STAGES(SFL_SYNC_STAGES), .RESET_LEVEL(1'b0)) u_sync_sclk (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_pin(i_serial_clk),
    .o_level(sclk_s)
  );
  sfl_pin_sync #(.STAGES(SFL_SYNC_STAGES), .RESET_LEVEL(1'b0)) u_sync_sdata (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_pin(i_serial_data),
    .o_level(sdata_s)
  );
  sfl_pin_sync #(.STAGES(SFL_SYNC_STAGES), .RESET_LEVEL(1'b0)) u_sync_slatch (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_pin(i_serial_latch),
    .o_level(slatch_s)
  );
  sfl_pin_sync #(.STAGES(SFL_SYNC_STAGES), .RESET_LEVEL(1'b0)) u_sync_ce (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_pin(i_chip_enable),
    .o_level(ce_s)
  );
  // Reference copy is only a low-rate image; a real buffer bypasses this clock
  sfl_pin_sync #(.STAGES(SFL_SYNC_STAGES), .RESET_LEVEL(1'b0)) u_sync_ref (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_pin(i_ref_input_pin),
    .o_level(ref_s)
  );

  // ----------------------------------------
  // Serial shift and word decode
  // ----------------------------------------
  logic sclk_prev_q;
  logic slatch_prev_q;
  logic [23:0] shift_q;
  logic [23:0] shift_d;

  wire logic sclk_rise = sclk_s && !sclk_prev_q;
  wire logic latch_rise = slatch_s && !slatch_prev_q;
  wire logic [3:0] ctrl_w = shift_q[3:0];
  wire logic load_fastlock = latch_rise && (ctrl_w == SFL_CTRL_FASTLOCK);
  wire logic load_frac_ext = latch_rise && (ctrl_w == SFL_CTRL_FRAC_EXT);
  wire logic load_freq = latch_rise && ((ctrl_w & SFL_FREQ_CTRL_MASK) == SFL_FREQ_CTRL_CODE);

  assign shift_d = sclk_rise ? {shift_q[22:0], sdata_s} : shift_q;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sclk_prev_q <= 1'b0;
      slatch_prev_q <= 1'b0;
      shift_q <= 24'h000000;
    end else begin
      sclk_prev_q <= sclk_s;
      slatch_prev_q <= slatch_s;
      shift_q <= shift_d;
    end
  end

  // ----------------------------------------
  // Word registers
  // ----------------------------------------
  logic [23:0] fastlock_condition_word_q;
  logic [23:0] fastlock_condition_word_d;
  logic [23:0] fraction_extension_word_q;
  logic [23:0] fraction_extension_word_d;
  logic word_loaded_q;

  assign fastlock_condition_word_d = load_fastlock ? shift_q : fastlock_condition_word_q;
  // Default mode overrides any written value, so stale extensions cannot leak
  assign fraction_extension_word_d = !i_ext_access ? SFL_FRAC_EXT_RESET :
    (load_frac_ext ? shift_q : fraction_extension_word_q);

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      fastlock_condition_word_q <= SFL_FASTLOCK_RESET;
      fraction_extension_word_q <= SFL_FRAC_EXT_RESET;
      word_loaded_q <= 1'b0;
    end else begin
      fastlock_condition_word_q <= fastlock_condition_word_d;
      fraction_extension_word_q <= fraction_extension_word_d;
      word_loaded_q <= load_fastlock || load_frac_ext;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire logic auto_power_up = fastlock_condition_word_q[SFL_AUTO_PU_BIT];
  wire logic [1:0] dither_level_select = fastlock_condition_word_q[SFL_DITHER_LSB +: 2];
  wire logic [1:0] modulator_order_select = fastlock_condition_word_q[SFL_FM_LSB +: 2];
  wire logic [3:0] test_lock_output_select = fastlock_condition_word_q[SFL_MUX_LSB +: 4];
  wire logic ref_buffer_output_enable = fastlock_condition_word_q[SFL_REF_OUT_BIT];
  wire logic [9:0] frac_numerator_extension = fraction_extension_word_q[SFL_NUM_EXT_LSB +: SFL_EXT_BITS];
  wire logic [9:0] frac_denominator_extension = fraction_extension_word_q[SFL_DEN_EXT_LSB +: SFL_EXT_BITS];

  assign o_aux_prescaler_16 = fastlock_condition_word_q[SFL_AUX_PRESC_BIT];
  assign o_main_pump_polarity = fastlock_condition_word_q[SFL_MAIN_CPP_BIT];
  assign o_aux_pump_polarity = fastlock_condition_word_q[SFL_AUX_CPP_BIT];
  assign o_ref_doubler_enable = fastlock_condition_word_q[SFL_DOUBLER_BIT];
  assign o_modulator_enable = (modulator_order_select != SFL_FM_OFF);
  assign o_modulator_order = (modulator_order_select == SFL_FM_FOURTH) ? 3'h4 :
    (modulator_order_select == SFL_FM_SECOND) ? 3'h2 :
    (modulator_order_select == SFL_FM_THIRD) ? 3'h3 : 3'h0;
  // Reserved dither code falls back to no dithering
  assign o_dither_level = (dither_level_select == SFL_DITH_RESERVED) ? 2'h0 : dither_level_select;
  assign o_frac_numerator = i_ext_access ? {frac_numerator_extension, i_frac_num_base} :
    {10'h000, i_frac_num_base};
  assign o_frac_denominator = i_ext_access ? {frac_denominator_extension, i_frac_den_base} :
    {10'h000, i_frac_den_base};
  assign o_word_loaded = word_loaded_q;

  // ----------------------------------------
  // Power-down control
  // ----------------------------------------
  logic main_pd_q;
  logic aux_pd_q;
  wire logic auto_pu_fire = load_freq && auto_power_up && ce_s;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      main_pd_q <= 1'b0;
      aux_pd_q <= 1'b0;
    end else if (i_pd_load) begin
      // An explicit power-down write wins over the automatic clear
      main_pd_q <= i_main_pd_value;
      aux_pd_q <= i_aux_pd_value;
    end else if (auto_pu_fire) begin
      main_pd_q <= 1'b0;
      aux_pd_q <= 1'b0;
    end
  end

  assign o_main_loop_powerdown = main_pd_q;
  assign o_aux_loop_powerdown = aux_pd_q || !ce_s;

  // ----------------------------------------
  // Test/lock pin and reference pin
  // ----------------------------------------
  logic [3:0] div_tog_q;
  logic tl_out_q;
  logic tl_oe_q;
  logic ref_out_q;
  logic ref_oe_q;

  wire logic [3:0] div_pulse = {i_main_n_div, i_main_r_div, i_aux_n_div, i_aux_r_div};
  wire logic ald_both = i_main_ald && i_aux_ald;
  wire logic [15:0] tl_val = {div_tog_q,
    i_aux_ald, i_main_ald, ald_both,
    i_aux_ald, i_main_ald, ald_both,
    i_aux_dld, i_main_dld, i_main_dld && i_aux_dld,
    1'b0, 1'b1, 1'b0};
  wire logic tl_od = (test_lock_output_select >= SFL_MUX_OD_FIRST) &&
    (test_lock_output_select <= SFL_MUX_OD_LAST);
  wire logic tl_sel_val = tl_val[test_lock_output_select];
  // Open drain only pulls low; released when the indication is high
  wire logic tl_oe_w = (test_lock_output_select != SFL_MUX_HIZ) && !(tl_od && tl_sel_val);
  wire logic tl_out_w = tl_od ? 1'b0 : tl_sel_val;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      div_tog_q <= 4'h0;
      tl_out_q <= 1'b0;
      tl_oe_q <= 1'b0;
      ref_out_q <= 1'b0;
      ref_oe_q <= 1'b0;
    end else begin
      div_tog_q <= div_tog_q ^ div_pulse;
      tl_out_q <= tl_out_w;
      tl_oe_q <= tl_oe_w;
      ref_out_q <= ref_buffer_output_enable && ref_s;
      ref_oe_q <= ref_buffer_output_enable;
    end
  end

  assign o_test_lock_pin_out = tl_out_q;
  assign o_test_lock_pin_oe = tl_oe_q;
  assign o_ref_output_pin_out = ref_out_q;
  assign o_ref_output_pin_oe = ref_oe_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_mux_hiz_off: assert property ((test_lock_output_select == 4'h0) |=> !o_test_lock_pin_oe)
    else $error("test/lock pin driven in disabled select");
  a_mux_fixed_lvl: assert property ((test_lock_output_select inside {4'h1, 4'h2}) |=> o_test_lock_pin_oe &&
    (o_test_lock_pin_out == $past(test_lock_output_select == 4'h1)))
    else $error("fixed level select drives wrong level");
  a_mux_dld_both: assert property ((test_lock_output_select == 4'h3)
    |=> o_test_lock_pin_oe && (o_test_lock_pin_out == $past(i_main_dld && i_aux_dld)))
    else $error("combined digital lock wrong on pin");
  a_mux_main_dld: assert property ((test_lock_output_select == 4'h4)
    |=> o_test_lock_pin_oe && (o_test_lock_pin_out == $past(i_main_dld)))
    else $error("main digital lock wrong on pin");
  a_mux_aux_dld: assert property ((test_lock_output_select == 4'h5)
    |=> o_test_lock_pin_out == $past(i_aux_dld))
    else $error("aux digital lock wrong on pin");
  a_ald_od_both: assert property ((test_lock_output_select == 4'h6)
    |=> !o_test_lock_pin_out && (o_test_lock_pin_oe == !$past(i_main_ald && i_aux_ald)))
    else $error("open-drain combined analog lock misdriven");
  a_ald_open_drain: assert property ((test_lock_output_select == 4'h7)
    |=> !o_test_lock_pin_out && (o_test_lock_pin_oe == !$past(i_main_ald)))
    else $error("open-drain analog lock misdriven");
  a_ald_push_pull: assert property ((test_lock_output_select == 4'hB)
    |=> o_test_lock_pin_oe && (o_test_lock_pin_out == $past(i_aux_ald)))
    else $error("push-pull analog lock misdriven");
  a_div_half_rate: assert property ((test_lock_output_select == 4'hE) && i_main_r_div
    ##1 (test_lock_output_select == 4'hE) |=> o_test_lock_pin_out != $past(o_test_lock_pin_out))
    else $error("divider output not toggling at half rate");
  a_div_aux_r: assert property ((test_lock_output_select == 4'hC) && i_aux_r_div
    ##1 (test_lock_output_select == 4'hC) |=> o_test_lock_pin_out != $past(o_test_lock_pin_out))
    else $error("aux R divider not toggling on pin");
  a_ref_buffer_hiz: assert property (!ref_buffer_output_enable |=> !o_ref_output_pin_oe && !o_ref_output_pin_out)
    else $error("reference pin driven while disabled");
  a_ref_buffer_copy: assert property (ref_buffer_output_enable |=> o_ref_output_pin_oe &&
    (o_ref_output_pin_out == $past(ref_s)))
    else $error("reference pin not copying input");
  a_auto_pu_clear: assert property (auto_pu_fire && !i_pd_load
    |=> !o_main_loop_powerdown && (o_aux_loop_powerdown == !ce_s))
    else $error("auto power-up did not clear power-down");
  a_freq_no_auto: assert property (load_freq && !auto_power_up && !i_pd_load
    |=> o_main_loop_powerdown == $past(o_main_loop_powerdown))
    else $error("power-down cleared without auto power-up");
  a_pd_load_wins: assert property (i_pd_load
    |=> o_main_loop_powerdown == $past(i_main_pd_value))
    else $error("explicit power-down value not taken");
  a_ce_blocks_pu: assert property (!ce_s && !i_pd_load |=> o_main_loop_powerdown == $past(o_main_loop_powerdown))
    else $error("power-down changed while chip enable low");
  a_ce_aux_down: assert property (!ce_s |-> o_aux_loop_powerdown)
    else $error("aux loop up while chip enable low");
  a_num_twelve_bit: assert property (!i_ext_access |-> o_frac_numerator[21:12] == 10'h000)
    else $error("numerator extension used in 12-bit mode");
  a_den_twelve_bit: assert property (!i_ext_access |-> o_frac_denominator[21:12] == 10'h000)
    else $error("denominator extension used in 12-bit mode");
  a_order_off: assert property ((modulator_order_select == SFL_FM_OFF)
    |-> !o_modulator_enable && (o_modulator_order == 3'h0))
    else $error("modulator not off for order code 1");
  a_order_on: assert property ((modulator_order_select != SFL_FM_OFF) |-> o_modulator_enable &&
    (o_modulator_order == ((modulator_order_select == SFL_FM_FOURTH) ? 3'h4 : {1'b0, modulator_order_select})))
    else $error("modulator order decode wrong");
  a_dither_pass: assert property ((dither_level_select != SFL_DITH_RESERVED)
    |-> o_dither_level == dither_level_select)
    else $error("dither level not passed on");
  a_ext_load_join: assert property (load_frac_ext && i_ext_access ##1 i_ext_access
    |-> o_frac_numerator[21:12] == $past(shift_q[13:4]))
    else $error("extension word not joined above base bits");
  a_ext_default: assert property (!i_ext_access |=> fraction_extension_word_q == SFL_FRAC_EXT_RESET)
    else $error("extension word not forced to default");
  a_fastlock_load: assert property (load_fastlock |=> (fastlock_condition_word_q == $past(shift_q)) && o_word_loaded)
    else $error("fastlock word not loaded");

  c_fastlock_write: cover property (load_fastlock ##1 o_word_loaded);
  c_ext_write: cover property (load_frac_ext && i_ext_access);
  c_auto_power_up: cover property (auto_pu_fire ##1 !o_main_loop_powerdown);
  c_open_drain_low: cover property ((test_lock_output_select == 4'h6) ##1 o_test_lock_pin_oe);
  c_div_toggle: cover property ((test_lock_output_select == 4'hE) && i_main_r_div);
endmodule

/* rtl/sfl_pin_sync.sv */
// Pin synchroniser with a two-stage agreement filter.
// Assumes an asynchronous pin level and one system clock.
`timescale 1ns/1ps
module sfl_pin_sync
  import sfl_pkg::*;
#(
  parameter int unsigned STAGES = SFL_SYNC_STAGES,
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_pin,
  output logic o_level
);
  // ----------------------------------------
  // Chain and filter
  // ----------------------------------------
  if (STAGES < 3) begin : g_bad_stages
    $error("sfl_pin_sync needs at least three stages");
  end

  logic [STAGES-1:0] chain_q;
  logic level_q;
  wire logic agree = (chain_q[STAGES-1] == chain_q[STAGES-2]);

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      chain_q <= {STAGES{RESET_LEVEL}};
      level_q <= RESET_LEVEL;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], i_pin};
      // Only change once the last two stages agree
      if (agree) begin
        level_q <= chain_q[STAGES-1];
      end
    end
  end

  assign o_level = level_q;
endmodule

/* rtl/sfl_pkg.sv */
// Constants for the fastlock condition and fraction extension word logic.
// Assumes 24-bit serial words, control code in the four lowest bits.
package sfl_pkg;
  // ----------------------------------------
  // Serial word layout
  // ----------------------------------------
  localparam int unsigned SFL_WORD_BITS = 24;
  localparam int unsigned SFL_CTRL_BITS = 4;
  localparam logic [3:0] SFL_CTRL_FASTLOCK = 4'h9;
  localparam logic [3:0] SFL_CTRL_FRAC_EXT = 4'hB;
  localparam logic [3:0] SFL_FREQ_CTRL_MASK = 4'h1;
  localparam logic [3:0] SFL_FREQ_CTRL_CODE = 4'h0;

  // ----------------------------------------
  // Fastlock condition word fields
  // ----------------------------------------
  localparam int unsigned SFL_AUTO_PU_BIT = 23;
  localparam int unsigned SFL_DITHER_LSB = 16;
  localparam int unsigned SFL_FM_LSB = 14;
  localparam int unsigned SFL_DOUBLER_BIT = 12;
  localparam int unsigned SFL_REF_OUT_BIT = 11;
  localparam int unsigned SFL_AUX_CPP_BIT = 10;
  localparam int unsigned SFL_MAIN_CPP_BIT = 9;
  localparam int unsigned SFL_AUX_PRESC_BIT = 8;
  localparam int unsigned SFL_MUX_LSB = 4;
  localparam logic [23:0] SFL_FASTLOCK_RESET = 24'h22C709;

  // ----------------------------------------
  // Fraction extension word fields
  // ----------------------------------------
  localparam int unsigned SFL_EXT_BITS = 10;
  localparam int unsigned SFL_BASE_BITS = 12;
  localparam int unsigned SFL_FRAC_BITS = 22;
  localparam int unsigned SFL_DEN_EXT_LSB = 14;
  localparam int unsigned SFL_NUM_EXT_LSB = 4;
  localparam logic [23:0] SFL_FRAC_EXT_RESET = 24'h00000B;

  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [1:0] SFL_FM_FOURTH = 2'h0;
  localparam logic [1:0] SFL_FM_OFF = 2'h1;
  localparam logic [1:0] SFL_FM_SECOND = 2'h2;
  localparam logic [1:0] SFL_FM_THIRD = 2'h3;
  localparam logic [1:0] SFL_DITH_RESERVED = 2'h3;
  localparam logic [3:0] SFL_MUX_HIZ = 4'h0;
  localparam logic [3:0] SFL_MUX_OD_FIRST = 4'h6;
  localparam logic [3:0] SFL_MUX_OD_LAST = 4'h8;
  localparam int unsigned SFL_SYNC_STAGES = 3;
endpackage

/* verif/sfl_fastlock_config_regs_tb.sv */
// Self-checking bench for the fastlock condition and fraction extension logic.
// Assumes the host model drives the serial pins; all else comes from here.
`timescale 1ns/1ps
module sfl_fastlock_config_regs_tb;
  import sfl_pkg::*;
  logic i_mclk, i_nrst, i_chip_enable, i_ref_input_pin, i_ext_access;
  logic i_pd_load, i_main_pd_value, i_aux_pd_value, sclk, sdata, slatch, slow;
  logic [11:0] i_frac_num_base, i_frac_den_base;
  logic [3:0] lock;
  logic [3:0] div;
  logic o_tl_out, o_tl_oe, o_ref_out, o_ref_oe, o_presc, o_mpol, o_apol, o_dbl, o_men;
  logic o_mpd, o_apd, o_loaded, pv, seen;
  logic [2:0] o_order;
  logic [1:0] o_dith;
  logic [21:0] o_num, o_den;
  logic [23:0] fl, ext, r;
  logic [57:0] exp_q[$], msk_q[$], e, m;
  int fails, compares, seed;

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  sfl_host_model sfl_host_model_i (.i_mclk(i_mclk), .i_slow(slow), .o_serial_clk(sclk),
    .o_serial_data(sdata), .o_serial_latch(slatch));

  sfl_fastlock_config_regs sfl_fastlock_config_regs_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_serial_clk(sclk), .i_serial_data(sdata), .i_serial_latch(slatch),
    .i_chip_enable(i_chip_enable), .i_ref_input_pin(i_ref_input_pin), .i_ext_access(i_ext_access),
    .i_frac_num_base(i_frac_num_base), .i_frac_den_base(i_frac_den_base), .i_pd_load(i_pd_load),
    .i_main_pd_value(i_main_pd_value), .i_aux_pd_value(i_aux_pd_value), .i_main_dld(lock[3]),
    .i_aux_dld(lock[2]), .i_main_ald(lock[1]), .i_aux_ald(lock[0]), .i_aux_r_div(div[0]),
    .i_aux_n_div(div[1]), .i_main_r_div(div[2]), .i_main_n_div(div[3]),
    .o_test_lock_pin_out(o_tl_out), .o_test_lock_pin_oe(o_tl_oe), .o_ref_output_pin_out(o_ref_out),
    .o_ref_output_pin_oe(o_ref_oe), .o_aux_prescaler_16(o_presc), .o_main_pump_polarity(o_mpol),
    .o_aux_pump_polarity(o_apol), .o_ref_doubler_enable(o_dbl), .o_modulator_enable(o_men),
    .o_modulator_order(o_order), .o_dither_level(o_dith), .o_main_loop_powerdown(o_mpd),
    .o_aux_loop_powerdown(o_apd), .o_frac_numerator(o_num), .o_frac_denominator(o_den),
    .o_word_loaded(o_loaded));

  // ----------------------------------------
  // Expected outputs from the word model
  // ----------------------------------------
  function automatic logic [57:0] obs();
    return {o_presc, o_mpol, o_apol, o_dbl, o_men, o_order, o_dith, o_ref_oe, o_ref_out, o_tl_oe, o_tl_out,
      o_num, o_den};
  endfunction

  // Pin data is masked when floating or showing a divider toggle
  task automatic calc(output logic [57:0] ev, output logic [57:0] mv);
    logic [3:0] mx;
    logic [1:0] fm;
    logic [1:0] di;
    logic po;
    logic pe;
    logic ind;
    logic [2:0] ord;
    mx = fl[7:4];
    fm = fl[15:14];
    di = fl[17:16];
    ord = (fm == SFL_FM_FOURTH) ? 3'h4 : (fm == SFL_FM_OFF) ? 3'h0 : {1'b0, fm};
    ind = (mx == 4'h6 || mx == 4'h9) ? (lock[1] & lock[0]) : (mx == 4'h7 || mx == 4'hA) ? lock[1] : lock[0];
    po = 1'b0;
    pe = 1'b1;
    case (mx)
      4'h0: pe = 1'b0;
      4'h1: po = 1'b1;
      4'h2: po = 1'b0;
      4'h3: po = lock[3] & lock[2];
      4'h4: po = lock[3];
      4'h5: po = lock[2];
      4'h6, 4'h7, 4'h8: pe = ~ind;
      default: po = ind;
    endcase
    ev = {fl[8], fl[9], fl[10], fl[12], fm != SFL_FM_OFF, ord, (di == SFL_DITH_RESERVED) ? 2'h0 : di,
      fl[11], fl[11] & i_ref_input_pin, pe, po, i_ext_access ? ext[13:4] : 10'h000, i_frac_num_base,
      i_ext_access ? ext[23:14] : 10'h000, i_frac_den_base};
    mv = {58{1'b1}};
    if (mx == 4'h0 || mx >= 4'hC) begin
      mv[44] = 1'b0;
    end
  endtask

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic fail(input string msg);
    fails++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic conclude();
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Each load pulse consumes the oldest note; pin outputs settle one cycle after it
  always @(negedge i_mclk) begin
    if (i_nrst === 1'b1 && seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail("unexpected load pulse");
      end else begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        compares++;
        if ((obs() & m) !== (e & m)) fail("word outputs wrong");
      end
    end
    seen = (i_nrst === 1'b1) && (o_loaded === 1'b1);
  end

  // ----------------------------------------
  // Stimulus helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic cmp_now(input string msg);
    calc(e, m);
    compares++;
    if ((obs() & m) !== (e & m)) fail(msg);
  endtask

  task automatic push_write(input logic [23:0] w);
    calc(e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    sfl_host_model_i.write_word(w);
    for (int k = 0; k < 40 && exp_q.size() != 0; k++) tick(1);
    if (exp_q.size() != 0) begin
      fail("load pulse timeout");
      conclude();
    end
  endtask

  task automatic write_fl(input logic [23:0] w);
    fl = w;
    push_write(w);
  endtask

  task automatic write_freq();
    r = $random(seed);
    sfl_host_model_i.write_word({r[23:1], 1'b0});
    tick(12);
  endtask

  task automatic pd(input logic mv, input logic av);
    i_main_pd_value = mv;
    i_aux_pd_value = av;
    i_pd_load = 1'b1;
    tick(1);
    i_pd_load = 1'b0;
    tick(2);
  endtask

  task automatic pd_chk(input logic mv, input logic av);
    compares++;
    if (o_mpd !== mv || o_apd !== av) fail("power-down state wrong");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 31690;
    fails = 0;
    compares = 0;
    i_nrst = 1'b0;
    i_chip_enable = 1'b1;
    i_ref_input_pin = 1'b0;
    i_ext_access = 1'b0;
    i_pd_load = 1'b0;
    i_main_pd_value = 1'b0;
    i_aux_pd_value = 1'b0;
    i_frac_num_base = 12'h3E8;
    i_frac_den_base = 12'h3E8;
    lock = 4'h0;
    div = 4'h0;
    slow = 1'b0;
    fl = SFL_FASTLOCK_RESET;
    ext = SFL_FRAC_EXT_RESET;
    tick(6);
    i_nrst = 1'b1;
    tick(10);
    cmp_now("reset values wrong");
    pd_chk(1'b0, 1'b0);
    // Every select, order and dither code, bits 23 and 12-8 random
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      lock = r[3:0];
      i_ref_input_pin = r[4];
      slow = r[5];
      write_fl({r[23], 5'h08, i[3:2], i[1:0], 1'b0, r[12:8], i[3:0], SFL_CTRL_FASTLOCK});
      if (i >= 12) begin
        pv = o_tl_out;
        div = ~(4'h1 << (i - 12));
        tick(1);
        div = 4'h0;
        tick(3);
        compares++;
        if (o_tl_out !== pv) fail("pin moved on unselected divider");
        div = 4'h1 << (i - 12);
        tick(1);
        div = 4'h0;
        tick(3);
        compares++;
        if (o_tl_out !== ~pv) fail("pin missed divider pulse");
      end
    end
    // Fraction extension at its limits, then default forcing
    i_ext_access = 1'b1;
    i_frac_num_base = 12'hFFF;
    i_frac_den_base = 12'hFFF;
    ext = 24'hFFFFFB;
    push_write(ext);
    i_frac_num_base = 12'h123;
    ext = {10'h001, 10'h200, SFL_CTRL_FRAC_EXT};
    push_write(ext);
    i_ext_access = 1'b0;
    ext = SFL_FRAC_EXT_RESET;
    tick(3);
    cmp_now("12-bit fraction wrong");
    i_ext_access = 1'b1;
    tick(3);
    cmp_now("extension not forced to default");
    sfl_host_model_i.write_word(24'hABCDE7);
    tick(20);
    cmp_now("foreign word changed outputs");
    // Automatic power-up with and without chip enable
    write_fl({1'b0, fl[22:0]});
    pd(1'b1, 1'b1);
    write_freq();
    pd_chk(1'b1, 1'b1);
    write_fl({1'b1, fl[22:0]});
    write_freq();
    pd_chk(1'b0, 1'b0);
    pd(1'b1, 1'b1);
    i_chip_enable = 1'b0;
    tick(10);
    write_freq();
    pd_chk(1'b1, 1'b1);
    pd(1'b0, 1'b0);
    pd_chk(1'b0, 1'b1);
    i_chip_enable = 1'b1;
    tick(10);
    pd_chk(1'b0, 1'b0);
    conclude();
  end
endmodule

/* verif/sfl_host_model.sv */
// Host side of the three-wire port: shifts 24-bit words into the block.
// Assumes the block samples the pins on i_mclk and filters them.
`timescale 1ns/1ps
module sfl_host_model (
  input wire logic i_mclk,
  input wire logic i_slow,
  output logic o_serial_clk,
  output logic o_serial_data,
  output logic o_serial_latch
);
  // ----------------------------------------
  // Pin levels between frames
  // ----------------------------------------
  // Clock and latch idle low; the clock stands still outside frames
  initial begin
    o_serial_clk = 1'b0;
    o_serial_data = 1'b0;
    o_serial_latch = 1'b0;
  end

  // ----------------------------------------
  // Word transfer
  // ----------------------------------------
  // Each level is held at least five cycles, longer when slow
  task automatic hold();
    repeat (i_slow ? 11 : 6) @(posedge i_mclk);
    #1;
  endtask

  task automatic write_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      o_serial_data = w[i];
      hold();
      o_serial_clk = 1'b1;
      hold();
      o_serial_clk = 1'b0;
    end
    o_serial_latch = 1'b1;
    hold();
    o_serial_latch = 1'b0;
    // Released data line must not keep its last value
    o_serial_data = ~o_serial_data;
    hold();
  endtask
endmodule
